// ---- pkg/watchdog_map.vh ----
// constants for the processor watchdog supervisor
`ifndef WATCHDOG_MAP_VH
`define WATCHDOG_MAP_VH
`define WD_CLK_HZ 40000000
`define WD_TIMEOUT_S 15
`define WD_REPEAT_S 10
`define WD_PULSE_MS 100
`define WD_FLASH_MS 250
`define WD_TIMEOUT_CYC (`WD_TIMEOUT_S * `WD_CLK_HZ)
`define WD_REPEAT_CYC (`WD_REPEAT_S * `WD_CLK_HZ)
`define WD_PULSE_CYC (`WD_PULSE_MS * (`WD_CLK_HZ / 1000))
`define WD_FLASH_CYC (`WD_FLASH_MS * (`WD_CLK_HZ / 1000))
`define WD_ST_OPERATE 1'b0
`define WD_ST_FAILED 1'b1
`endif

// ---- rtl/pulse_timer.v ----
// loadable down-counter that flags expiry
`timescale 1ns/10ps
`default_nettype none
module pulse_timer #(
    parameter WIDTH = 32
) (
    input wire sys_clk,
    input wire rst_n,
    input wire load,
    input wire [WIDTH-1:0] loadValue,
    input wire run,
    output wire expired
);
    reg [WIDTH-1:0] count_reg;
    reg [WIDTH-1:0] count_next;

    always @* begin
        count_next = count_reg;
        if (load) begin
            count_next = loadValue;
        end else if (run && count_reg != {WIDTH{1'b0}}) begin
            count_next = count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= {WIDTH{1'b0}};
        end else begin
            count_reg <= count_next;
        end
    end

    assign expired = run &&
        (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// ---- rtl/processor_watchdog_supervisor.v ----
// supervisory watchdog that resets the processing unit on missed kicks
// Overview of operation
// R1: software toggles the kick line periodically to show it is alive
// R2: each kick pulse restarts the full timeout interval
// R3: no kick for 15 seconds puts the watchdog into failure
// R4: while failed, the failure lamp output flashes
// R5: while failed, an interval generator fires every 10 seconds
// R6: each firing yields one 100 ms reset pulse on the bus reset line
// R7: a kick after failure lights operate lamp, clears failure
// R8: software keeps kicking during power-up tape track search
// R9: if power-on reset fails, watchdog resets after the 15 s timeout
// R10: ground support station attached holds timers off, no reset
// R11: after reset the watchdog starts operating, timeout fresh, lamp off
// R12: all intervals are counted in system clock cycles by parameters
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_map.vh"
module processor_watchdog_supervisor #(
    parameter TIMEOUT_CYC = `WD_TIMEOUT_CYC,
    parameter REPEAT_CYC = `WD_REPEAT_CYC,
    parameter PULSE_CYC = `WD_PULSE_CYC,
    parameter FLASH_CYC = `WD_FLASH_CYC
) (
    input wire sys_clk,
    input wire rst_n,
    input wire kickLine,
    input wire groundStationCts,
    output reg busReset,
    output reg failureLamp,
    output reg operateLamp
);
    // pin synchronisers and edge detect
    reg kickMeta;
    reg kickSync;
    reg kickLast;
    reg gseMeta;
    reg gseSync;
    reg state_reg;
    reg firstRun_reg;
    reg pulseActive_reg;
    reg flashPhase_reg;
    reg state_next;
    reg pulseActive_next;
    reg flashPhase_next;
    reg [1:0] settle_reg;
    reg [1:0] settle_next;
    reg busReset_next;
    reg failureLamp_next;
    reg operateLamp_next;

    wire kickEdge;
    wire timeoutExpired;
    wire repeatExpired;
    wire pulseExpired;
    wire flashExpired;
    wire failed;
    wire loadTimeout;
    wire loadRepeat;
    wire fireReset;
    wire armed;
    wire timeoutDue;
    wire timeoutRun;
    wire repeatRun;

    // two-stage synchronisers for the pins
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            kickMeta <= 1'b0;
            kickSync <= 1'b0;
            kickLast <= 1'b0;
        end else begin
            kickMeta <= kickLine;
            kickSync <= kickMeta;
            kickLast <= kickSync;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gseMeta <= 1'b0;
            gseSync <= 1'b0;
        end else begin
            gseMeta <= groundStationCts;
            gseSync <= gseMeta;
        end
    end

    // any toggle counts as a kick, once the pipe holds real pin levels
    assign armed = (settle_reg == 2'h3);
    assign kickEdge = armed && (kickSync ^ kickLast); // see R1
    assign failed = (state_reg == `WD_ST_FAILED);
    // kicks, station attach and the start after reset reload timeout
    assign loadTimeout = kickEdge || gseSync || firstRun_reg; // see R2
    assign timeoutDue = timeoutExpired && !loadTimeout; // see R3
    assign loadRepeat = !failed || gseSync;
    assign fireReset = (timeoutDue || (failed && repeatExpired))
        && !gseSync; // see R9
    // timeout and repeat timers stand still while the station is attached
    assign timeoutRun = !failed && !gseSync; // see R10
    assign repeatRun = failed && !gseSync; // see R10

    // retriggerable timeout, reloaded by every kick
    pulse_timer #(.WIDTH(32)) timeoutTimer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(loadTimeout),
        .loadValue(TIMEOUT_CYC), // see R12
        .run(timeoutRun), // see R10
        .expired(timeoutExpired)
    );

    // free-running repeat interval while failed
    pulse_timer #(.WIDTH(32)) repeatTimer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(loadRepeat || repeatExpired),
        .loadValue(REPEAT_CYC), // see R5
        .run(repeatRun),
        .expired(repeatExpired)
    );

    // length of one reset pulse
    pulse_timer #(.WIDTH(32)) pulseTimer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(fireReset),
        .loadValue(PULSE_CYC), // see R6
        .run(pulseActive_reg),
        .expired(pulseExpired)
    );

    // half period of the failure lamp flash
    pulse_timer #(.WIDTH(32)) flashTimer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(!failed || flashExpired),
        .loadValue(FLASH_CYC),
        .run(failed),
        .expired(flashExpired)
    );

    // next state of the supervisor
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `WD_ST_OPERATE: begin
                if (timeoutDue) begin
                    state_next = `WD_ST_FAILED; // see R3
                end
            end
            `WD_ST_FAILED: begin
                if (kickEdge) begin
                    state_next = `WD_ST_OPERATE; // see R7
                end
            end
            default: begin
                state_next = `WD_ST_OPERATE;
            end
        endcase
    end

    // reset pulse: started by firing, ended by its own timer
    always @* begin
        pulseActive_next = pulseActive_reg;
        if (gseSync) begin
            pulseActive_next = 1'b0; // see R10
        end else if (fireReset) begin
            pulseActive_next = 1'b1; // see R6
        end else if (pulseExpired) begin
            pulseActive_next = 1'b0;
        end
    end

    // flash phase toggles only while failed
    always @* begin
        flashPhase_next = flashPhase_reg;
        if (!failed || kickEdge) begin
            flashPhase_next = 1'b0;
        end else if (flashExpired) begin
            flashPhase_next = !flashPhase_reg; // see R4
        end
    end

    // counts the first edges after reset while the pipes fill
    always @* begin
        settle_next = settle_reg;
        if (settle_reg != 2'h3) begin
            settle_next = settle_reg + 2'h1;
        end
    end

    // output values, registered below
    always @* begin
        busReset_next = pulseActive_reg && !gseSync;
        failureLamp_next = failed && !kickEdge && flashPhase_reg;
        operateLamp_next = !failed || kickEdge; // see R7
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= `WD_ST_OPERATE; // see R11
            settle_reg <= 2'h0;
            firstRun_reg <= 1'b1;
            pulseActive_reg <= 1'b0;
            flashPhase_reg <= 1'b0;
            busReset <= 1'b0;
            failureLamp <= 1'b0;
            operateLamp <= 1'b0;
        end else begin
            state_reg <= state_next;
            settle_reg <= settle_next;
            firstRun_reg <= 1'b0;
            pulseActive_reg <= pulseActive_next;
            flashPhase_reg <= flashPhase_next;
            busReset <= busReset_next;
            failureLamp <= failureLamp_next;
            operateLamp <= operateLamp_next;
        end
    end
endmodule
`default_nettype wire

// ---- sim/wd_checker.sv ----
// watchdog port checker
`timescale 1ns/10ps
`default_nettype none
module wd_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic kickLine,
    input wire logic groundStationCts,
    input wire logic busReset,
    input wire logic failureLamp,
    input wire logic operateLamp
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    lamp_mix_a: assert property (operateLamp |-> !failureLamp)
        else $error("lamps");
    lamp_flash_a: assert property ($fell(operateLamp) |->
        ##[1:7] $changed(failureLamp)) else $error("flash");
    kick_back_a: assert property (!operateLamp && $changed(kickLine)
        |-> ##[1:5] operateLamp) else $error("recover");
    kick_hold_a: assert property ($changed(kickLine) && operateLamp
        |=> (!$rose(busReset))[*8]) else $error("early");
    pulse_len_a: assert property ($rose(busReset) |->
        busReset[*8] ##[2:4] !busReset) else $error("pulse");
    pulse_again_a: assert property ($rose(busReset) |->
        ##[110:125] ($rose(busReset) || operateLamp)) else $error("repeat");
    fail_reset_a: assert property ($fell(operateLamp) |->
        ##[0:3] busReset) else $error("timeout");
    station_hold_a: assert property (groundStationCts[*5] |->
        !busReset) else $error("station");
endmodule
bind processor_watchdog_supervisor wd_checker watch (.*);
`default_nettype wire

// ---- sim/kick_source.sv ----
// stand-in for the software kick routine
`timescale 1ns/10ps
`default_nettype none
module kick_source (
    input wire logic sys_clk,
    input wire logic alive,
    output logic kickLine = 1'b0
);
    logic [4:0] gap = 5'h0;
    always @(posedge sys_clk) begin
        gap <= (gap == 5'h14) ? 5'h0 : gap + 5'h1;
        if (alive && gap == 5'h14) kickLine <= !kickLine;
    end
endmodule
`default_nettype wire

// ---- sim/processor_watchdog_supervisor_tb_top.sv ----
// watchdog supervisor bench
`timescale 1ns/10ps
`default_nettype none
module processor_watchdog_supervisor_tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, alive = 1'b0, groundStationCts = 1'b0;
    wire logic kickLine, busReset, failureLamp, operateLamp;
    int miscompares = 0, samples_checked = 0, rises = 0, n, r;
    always #12.5 sys_clk = !sys_clk;
    always @(posedge busReset) rises++;
    kick_source src (.*);
    processor_watchdog_supervisor #(.TIMEOUT_CYC(200), .REPEAT_CYC(120),
        .PULSE_CYC(10), .FLASH_CYC(5)) DUT (.*);
    task end_sim;
        $display("checks %0d errors %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input bit ok);
        samples_checked++;
        if (!ok) miscompares++;
        if (!ok) $display("Error %0t: mismatch", $time);
    endtask
    task wait_rise(input int lim);
        r = rises;
        for (n = 0; rises == r && n < lim; n++) @(posedge sys_clk);
        chk(n < lim);
        if (n >= lim) end_sim();
    endtask
    task do_reset;
        rst_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1 chk({operateLamp, failureLamp, busReset} === 3'b100);
    endtask
    task lapse;
        alive <= 1'b1;
        repeat (700) @(posedge sys_clk);
        chk(rises == 0);
        alive <= 1'b0;
        wait_rise(300);
        chk(n > 180 && n < 212 && operateLamp === 1'b0);
        wait_rise(200);
        chk(n > 117 && n < 123);
        alive <= 1'b1;
        repeat (40) @(posedge sys_clk);
        chk({operateLamp, failureLamp} === 2'b10);
    endtask
    task station;
        groundStationCts <= 1'b1;
        alive <= 1'b0;
        n = rises;
        repeat (400) @(posedge sys_clk);
        chk(rises == n && operateLamp === 1'b1);
        groundStationCts <= 1'b0;
    endtask
    initial begin
        do_reset();
        lapse();
        station();
        wait_rise(300);
        do_reset();
        end_sim();
    end
endmodule
`default_nettype wire
